// File: include/lcdan_defs.vh
`ifndef LCDAN_DEFS_VH
`define LCDAN_DEFS_VH

// ==========================================
// register byte offsets
`define LCDAN_OFS_FUNC 8'h00
`define LCDAN_OFS_RANGE 8'h04
`define LCDAN_OFS_FLAGS 8'h08
`define LCDAN_OFS_DIG_LO 8'h0c
`define LCDAN_OFS_DIG_HI 8'h10
`define LCDAN_OFS_BAR_LO 8'h14
`define LCDAN_OFS_BAR_HI 8'h18
`define LCDAN_OFS_STAT 8'h1c
`define LCDAN_OFS_ROW1 8'h20
`define LCDAN_OFS_ROW2 8'h24
`define LCDAN_OFS_ROW3 8'h28
`define LCDAN_OFS_ROW4 8'h2c

// ==========================================
// measurement function codes
`define LCDAN_FN_VOLT 7'h3b
`define LCDAN_FN_UAMP 7'h3d
`define LCDAN_FN_MAMP 7'h3f
`define LCDAN_FN_A22 7'h30
`define LCDAN_FN_AMAN 7'h39
`define LCDAN_FN_OHM 7'h33
`define LCDAN_FN_CONT 7'h35
`define LCDAN_FN_DIODE 7'h31
`define LCDAN_FN_FREQ 7'h32
`define LCDAN_FN_CAP 7'h36
`define LCDAN_FN_TEMP 7'h34
`define LCDAN_FN_ADP 7'h3e

// ==========================================
// range codes: band is 0x30..0x37
`define LCDAN_RG_BAND 4'h6
`define LCDAN_RG_220MV 7'h34

// ==========================================
// flag register fields
`define LCDAN_FL_AUTO 0
`define LCDAN_FL_HOLD 1
`define LCDAN_FL_RELATIVE 2
`define LCDAN_FL_MAX 3
`define LCDAN_FL_MIN 4
`define LCDAN_FL_PKHI 5
`define LCDAN_FL_PKLO 6
`define LCDAN_FL_JUDGE 7
`define LCDAN_FL_AC 8
`define LCDAN_FL_VBAR 9
`define LCDAN_FL_IDLE_OFF 10
`define LCDAN_FL_SER 11
`define LCDAN_FL_LOW_BAT 12
`define LCDAN_FL_MINUS 13
`define LCDAN_FL_TEST 14
`define LCDAN_FL_BLANK 15
`define LCDAN_FL_W 16

// ==========================================
// reset values and bus answers
`define LCDAN_RST_FUNC 7'h3b
`define LCDAN_RST_RANGE 7'h30
`define LCDAN_RST_FLAGS 16'h0001
`define LCDAN_RESP_OKAY 2'h0
`define LCDAN_RESP_SLVERR 2'h2

`endif

// File: core/lcdan_range_dec.v
`timescale 1ns/1ps
`include "lcdan_defs.vh"

module lcdan_range_dec (
	input wire [6:0] i_func,
	input wire [6:0] i_range,
	input wire i_vbar,
	output wire o_capacitance_milli_prefix,
	output wire o_cap_micro,
	output wire o_cap_nano,
	output wire o_volt_amp_milli_prefix,
	output wire o_amp_micro,
	output wire o_ohm_mega,
	output wire o_ohm_kilo,
	output wire [4:0] o_adapter_range
);
	wire in_band = (i_range[6:3] == `LCDAN_RG_BAND);
	wire [2:0] ridx = i_range[2:0];
	wire is_cap = (i_func == `LCDAN_FN_CAP) & in_band;
	wire is_ohm = (i_func == `LCDAN_FN_OHM) & in_band;
	wire is_adp = (i_func == `LCDAN_FN_ADP) & in_band;
	// vbar set turns the auto current functions into amp-only ranges
	wire is_ua = (i_func == `LCDAN_FN_UAMP) & ~i_vbar;
	wire is_ma = (i_func == `LCDAN_FN_MAMP) & ~i_vbar;
	wire is_mv = (i_func == `LCDAN_FN_VOLT) & (i_range == `LCDAN_RG_220MV);

	assign o_cap_nano = is_cap & (ridx <= 3'h1);
	assign o_cap_micro = is_cap & (ridx >= 3'h2) & (ridx <= 3'h4);
	assign o_capacitance_milli_prefix = is_cap & (ridx >= 3'h5);
	assign o_volt_amp_milli_prefix = is_mv | is_ma;
	assign o_amp_micro = is_ua;
	assign o_ohm_kilo = is_ohm & (ridx >= 3'h1) & (ridx <= 3'h3);
	assign o_ohm_mega = is_ohm & (ridx >= 3'h4) & (ridx <= 3'h6);
	// adapter ranges count downward from code 0x30
	assign o_adapter_range[0] = is_adp & (ridx == 3'h4);
	assign o_adapter_range[1] = is_adp & (ridx == 3'h3);
	assign o_adapter_range[2] = is_adp & (ridx == 3'h2);
	assign o_adapter_range[3] = is_adp & (ridx == 3'h1);
	assign o_adapter_range[4] = is_adp & (ridx == 3'h0);
endmodule // lcdan_range_dec

// File: core/lcdan_axil.v
`timescale 1ns/1ps
`include "lcdan_defs.vh"

module lcdan_axil (
	input wire i_sys_clk,
	input wire i_arst_n,
	input wire [7:0] i_awaddr,
	input wire i_awvalid,
	output wire o_awready,
	input wire [31:0] i_wdata,
	input wire [3:0] i_wstrb,
	input wire i_wvalid,
	output wire o_wready,
	output wire [1:0] o_bresp,
	output wire o_bvalid,
	input wire i_bready,
	input wire [7:0] i_araddr,
	input wire i_arvalid,
	output wire o_arready,
	output wire [31:0] o_rdata,
	output wire [1:0] o_rresp,
	output wire o_rvalid,
	input wire i_rready,
	output wire o_wr_en,
	output wire [7:0] o_wr_addr,
	output wire [31:0] o_wr_data,
	output wire [3:0] o_wr_strb,
	input wire i_wr_ok,
	output wire [7:0] o_rd_addr,
	input wire [31:0] i_rd_data,
	input wire i_rd_ok
);
	reg aw_full_reg;
	reg w_full_reg;
	reg [7:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg rvalid_reg;
	reg [1:0] rresp_reg;
	reg [31:0] rdata_reg;

	assign o_awready = ~aw_full_reg;
	assign o_wready = ~w_full_reg;
	assign o_wr_en = aw_full_reg & w_full_reg & ~bvalid_reg;
	assign o_wr_addr = awaddr_reg;
	assign o_wr_data = wdata_reg;
	assign o_wr_strb = wstrb_reg;
	assign o_bvalid = bvalid_reg;
	assign o_bresp = bresp_reg;
	assign o_arready = ~rvalid_reg;
	assign o_rd_addr = i_araddr;
	assign o_rvalid = rvalid_reg;
	assign o_rresp = rresp_reg;
	assign o_rdata = rdata_reg;

	// ==========================================
	// write path: address and data land in either order
	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `LCDAN_RESP_OKAY;
		end else begin
			if (i_awvalid && !aw_full_reg) begin
				aw_full_reg <= 1'b1;
				awaddr_reg <= i_awaddr;
			end
			if (i_wvalid && !w_full_reg) begin
				w_full_reg <= 1'b1;
				wdata_reg <= i_wdata;
				wstrb_reg <= i_wstrb;
			end
			if (o_wr_en) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= i_wr_ok ? `LCDAN_RESP_OKAY : `LCDAN_RESP_SLVERR;
			end else if (bvalid_reg && i_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// read path
	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rvalid_reg <= 1'b0;
			rresp_reg <= `LCDAN_RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
		end else if (i_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= i_rd_ok ? `LCDAN_RESP_OKAY : `LCDAN_RESP_SLVERR;
			rdata_reg <= i_rd_ok ? i_rd_data : 32'h0000_0000;
		end else if (rvalid_reg && i_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
endmodule // lcdan_axil

// File: core/lcdan_top.v
`timescale 1ns/1ps
`include "lcdan_defs.vh"

module lcdan_top (
	input wire i_sys_clk,
	input wire i_arst_n,
	input wire [7:0] i_awaddr,
	input wire i_awvalid,
	output wire o_awready,
	input wire [31:0] i_wdata,
	input wire [3:0] i_wstrb,
	input wire i_wvalid,
	output wire o_wready,
	output wire [1:0] o_bresp,
	output wire o_bvalid,
	input wire i_bready,
	input wire [7:0] i_araddr,
	input wire i_arvalid,
	output wire o_arready,
	output wire [31:0] o_rdata,
	output wire [1:0] o_rresp,
	output wire o_rvalid,
	input wire i_rready,
	output wire [30:0] o_backplane_line_one,
	output wire [30:0] o_backplane_line_two,
	output wire [30:0] o_backplane_line_three,
	output wire [30:0] o_backplane_line_four
);
	// ==========================================
	// byte-lane merge for partial writes
	function [31:0] lcdan_merge;
		input [31:0] old_v;
		input [31:0] wr_v;
		input [3:0] strb;
		integer b;
		begin
			lcdan_merge = old_v;
			for (b = 0; b < 4; b = b + 1) begin
				if (strb[b]) begin
					lcdan_merge[b*8 +: 8] = wr_v[b*8 +: 8];
				end
			end
		end
	endfunction

	// ==========================================
	// register state
	reg [6:0] func_reg;
	reg [6:0] range_reg;
	reg [15:0] flag_reg;
	reg [27:0] dig_lo_reg;
	reg [10:0] dig_hi_reg;
	reg [31:0] bar_lo_reg;
	reg [13:0] bar_hi_reg;
	reg [30:0] row1_reg;
	reg [30:0] row2_reg;
	reg [30:0] row3_reg;
	reg [30:0] row4_reg;

	wire wr_en;
	wire [7:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire [7:0] rd_addr;
	reg [31:0] rd_data;
	reg rd_ok;
	reg wr_ok;

	lcdan_axil u_bus (
		.i_sys_clk(i_sys_clk),
		.i_arst_n(i_arst_n),
		.i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid),
		.o_awready(o_awready),
		.i_wdata(i_wdata),
		.i_wstrb(i_wstrb),
		.i_wvalid(i_wvalid),
		.o_wready(o_wready),
		.o_bresp(o_bresp),
		.o_bvalid(o_bvalid),
		.i_bready(i_bready),
		.i_araddr(i_araddr),
		.i_arvalid(i_arvalid),
		.o_arready(o_arready),
		.o_rdata(o_rdata),
		.o_rresp(o_rresp),
		.o_rvalid(o_rvalid),
		.i_rready(i_rready),
		.o_wr_en(wr_en),
		.o_wr_addr(wr_addr),
		.o_wr_data(wr_data),
		.o_wr_strb(wr_strb),
		.i_wr_ok(wr_ok),
		.o_rd_addr(rd_addr),
		.i_rd_data(rd_data),
		.i_rd_ok(rd_ok)
	);

	// ==========================================
	// register writes
	always @* begin
		case (wr_addr)
			`LCDAN_OFS_FUNC, `LCDAN_OFS_RANGE, `LCDAN_OFS_FLAGS,
			`LCDAN_OFS_DIG_LO, `LCDAN_OFS_DIG_HI,
			`LCDAN_OFS_BAR_LO, `LCDAN_OFS_BAR_HI: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// merged words are cut back to each field's width on purpose
	wire [31:0] func_next =
		lcdan_merge({25'h0, func_reg}, wr_data, wr_strb);
	wire [31:0] range_next =
		lcdan_merge({25'h0, range_reg}, wr_data, wr_strb);
	wire [31:0] flag_next =
		lcdan_merge({16'h0, flag_reg}, wr_data, wr_strb);
	wire [31:0] dig_lo_next =
		lcdan_merge({4'h0, dig_lo_reg}, wr_data, wr_strb);
	wire [31:0] dig_hi_next =
		lcdan_merge({21'h0, dig_hi_reg}, wr_data, wr_strb);
	wire [31:0] bar_hi_next =
		lcdan_merge({18'h0, bar_hi_reg}, wr_data, wr_strb);

	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			func_reg <= `LCDAN_RST_FUNC;
			range_reg <= `LCDAN_RST_RANGE;
			flag_reg <= `LCDAN_RST_FLAGS;
			dig_lo_reg <= 28'h0000000;
			dig_hi_reg <= 11'h000;
			bar_lo_reg <= 32'h0000_0000;
			bar_hi_reg <= 14'h0000;
		end else if (wr_en) begin
			case (wr_addr)
				`LCDAN_OFS_FUNC: func_reg <=
					func_next[6:0];
				`LCDAN_OFS_RANGE: range_reg <=
					range_next[6:0];
				`LCDAN_OFS_FLAGS: flag_reg <=
					flag_next[15:0];
				`LCDAN_OFS_DIG_LO: dig_lo_reg <=
					dig_lo_next[27:0];
				`LCDAN_OFS_DIG_HI: dig_hi_reg <=
					dig_hi_next[10:0];
				`LCDAN_OFS_BAR_LO: bar_lo_reg <=
					lcdan_merge(bar_lo_reg, wr_data, wr_strb);
				`LCDAN_OFS_BAR_HI: bar_hi_reg <=
					bar_hi_next[13:0];
				default: func_reg <= func_reg;
			endcase
		end
	end

	// ==========================================
	// function classes
	wire is_volt = (func_reg == `LCDAN_FN_VOLT);
	wire is_amp = (func_reg == `LCDAN_FN_UAMP) |
		(func_reg == `LCDAN_FN_MAMP) |
		(func_reg == `LCDAN_FN_A22) |
		(func_reg == `LCDAN_FN_AMAN);
	wire is_ohm = (func_reg == `LCDAN_FN_OHM);
	wire is_cont = (func_reg == `LCDAN_FN_CONT);
	wire is_diode = (func_reg == `LCDAN_FN_DIODE);
	wire is_freq = (func_reg == `LCDAN_FN_FREQ);
	wire is_cap = (func_reg == `LCDAN_FN_CAP);
	wire is_temp = (func_reg == `LCDAN_FN_TEMP);
	wire judge = flag_reg[`LCDAN_FL_JUDGE];
	wire ac_sel = flag_reg[`LCDAN_FL_AC];

	// ==========================================
	// annunciators
	wire volt_sym = is_volt | is_diode;
	wire amp_sym = is_amp;
	wire ohm_sym = is_ohm | is_cont;
	wire farad_sym = is_cap;
	wire cont_sym = is_cont;
	wire diode_sym = is_diode;
	wire dc_sym = (is_volt | is_amp) & ~ac_sel;
	wire ac_sym = (is_volt | is_amp) & ac_sel;
	wire auto_sym = flag_reg[`LCDAN_FL_AUTO];
	wire manual_range_symbol = ~flag_reg[`LCDAN_FL_AUTO];
	wire hold_sym = flag_reg[`LCDAN_FL_HOLD];
	wire relative_reading_symbol = flag_reg[`LCDAN_FL_RELATIVE];
	// only one extreme is on show, max wins a conflicting setting
	wire max_sym = flag_reg[`LCDAN_FL_MAX];
	wire min_sym = flag_reg[`LCDAN_FL_MIN] & ~max_sym;
	wire peak_high_symbol = flag_reg[`LCDAN_FL_PKHI];
	wire peak_low_symbol = flag_reg[`LCDAN_FL_PKLO] & ~peak_high_symbol;
	wire hz_sym = is_freq & judge;
	wire pct_sym = is_freq & ~judge;
	wire degc_sym = is_temp & judge;
	wire degf_sym = is_temp & ~judge;
	wire idle_power_down_symbol = flag_reg[`LCDAN_FL_IDLE_OFF];
	wire serial_sym = flag_reg[`LCDAN_FL_SER];
	wire low_battery_symbol = flag_reg[`LCDAN_FL_LOW_BAT];
	wire minus_sym = flag_reg[`LCDAN_FL_MINUS];

	wire capacitance_milli_prefix;
	wire cap_micro;
	wire cap_nano;
	wire volt_amp_milli_prefix;
	wire amp_micro;
	wire ohm_mega;
	wire ohm_kilo;
	wire [4:0] adp;

	lcdan_range_dec u_range (
		.i_func(func_reg),
		.i_range(range_reg),
		.i_vbar(flag_reg[`LCDAN_FL_VBAR]),
		.o_capacitance_milli_prefix(capacitance_milli_prefix),
		.o_cap_micro(cap_micro),
		.o_cap_nano(cap_nano),
		.o_volt_amp_milli_prefix(volt_amp_milli_prefix),
		.o_amp_micro(amp_micro),
		.o_ohm_mega(ohm_mega),
		.o_ohm_kilo(ohm_kilo),
		.o_adapter_range(adp)
	);

	// ==========================================
	// digits: bit 0 is segment a up to bit 6 for g
	wire [6:0] d1 = dig_lo_reg[6:0];
	wire [6:0] d2 = dig_lo_reg[13:7];
	wire [6:0] d3 = dig_lo_reg[20:14];
	wire [6:0] d4 = dig_lo_reg[27:21];
	wire [6:0] d5 = dig_hi_reg[6:0];
	wire [3:0] dp = dig_hi_reg[10:7];
	wire [45:0] bar = {bar_hi_reg, bar_lo_reg};

	// ==========================================
	// glass matrix, bit 0 of each row is the first segment line
	wire [30:0] map1 = {1'b0, cap_nano, adp[1], relative_reading_symbol,
		amp_sym, volt_sym, volt_amp_milli_prefix, amp_micro,
		d1[1], d1[0], degf_sym, degc_sym, pct_sym, d2[0],
		cont_sym, diode_sym, d3[1], d3[0], d3[5], hold_sym,
		d4[1], d4[0], d4[5], manual_range_symbol,
		d5[1], d5[0], d5[5], auto_sym, dc_sym,
		idle_power_down_symbol, low_battery_symbol};
	wire [30:0] map2 = {peak_high_symbol, cap_micro, adp[2], max_sym,
		hz_sym, ohm_sym, ohm_kilo, ohm_mega,
		d1[2], d1[6], d1[5], dp[0], d2[1], d2[6], d2[5], dp[1],
		d3[2], d3[6], d3[4], dp[2], d4[2], d4[6], d4[4], dp[3],
		d5[2], d5[6], d5[4], minus_sym, ac_sym, serial_sym,
		minus_sym};
	wire [30:0] map3 = {peak_low_symbol, capacitance_milli_prefix,
		adp[3], min_sym,
		bar[44], bar[42], bar[40], bar[38], bar[36],
		d1[3], d1[4], bar[32], d2[2], d2[3], d2[4],
		bar[27], bar[25], d3[3], bar[22], bar[20], bar[18],
		d4[3], bar[15], bar[13], bar[11], d5[3],
		bar[8], bar[6], bar[4], bar[2], bar[0]};
	wire [30:0] map4 = {1'b0, farad_sym, adp[4], adp[0],
		bar[45], bar[43], bar[41], bar[39], bar[37], bar[35],
		bar[34], bar[33], bar[31], bar[30], bar[29], bar[28],
		bar[26], bar[24], bar[23], bar[21], bar[19], bar[17],
		bar[16], bar[14], bar[12], bar[10], bar[9], bar[7],
		bar[5], bar[3], bar[1]};

	// test lights every crossing; blank overrides it
	wire test_on = flag_reg[`LCDAN_FL_TEST];
	wire blank_on = flag_reg[`LCDAN_FL_BLANK];
	wire [30:0] all_on = 31'h7fff_ffff;

	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			row1_reg <= 31'h0000_0000;
			row2_reg <= 31'h0000_0000;
			row3_reg <= 31'h0000_0000;
			row4_reg <= 31'h0000_0000;
		end else if (blank_on) begin
			row1_reg <= 31'h0000_0000;
			row2_reg <= 31'h0000_0000;
			row3_reg <= 31'h0000_0000;
			row4_reg <= 31'h0000_0000;
		end else if (test_on) begin
			row1_reg <= all_on;
			row2_reg <= all_on;
			row3_reg <= all_on;
			row4_reg <= all_on;
		end else begin
			row1_reg <= map1;
			row2_reg <= map2;
			row3_reg <= map3;
			row4_reg <= map4;
		end
	end

	assign o_backplane_line_one = row1_reg;
	assign o_backplane_line_two = row2_reg;
	assign o_backplane_line_three = row3_reg;
	assign o_backplane_line_four = row4_reg;

	// ==========================================
	// decoded symbol readback
	wire [31:0] stat = {adp, capacitance_milli_prefix, cap_micro,
		cap_nano, volt_amp_milli_prefix, amp_micro, ohm_mega, ohm_kilo,
		peak_low_symbol, peak_high_symbol, min_sym, max_sym,
		relative_reading_symbol, hold_sym, manual_range_symbol,
		auto_sym, ac_sym, dc_sym, degf_sym, degc_sym, pct_sym,
		hz_sym, diode_sym, cont_sym, farad_sym, ohm_sym, amp_sym,
		volt_sym};

	// ==========================================
	// register reads
	always @* begin
		rd_ok = 1'b1;
		case (rd_addr)
			`LCDAN_OFS_FUNC: rd_data = {25'h0, func_reg};
			`LCDAN_OFS_RANGE: rd_data = {25'h0, range_reg};
			`LCDAN_OFS_FLAGS: rd_data = {16'h0, flag_reg};
			`LCDAN_OFS_DIG_LO: rd_data = {4'h0, dig_lo_reg};
			`LCDAN_OFS_DIG_HI: rd_data = {21'h0, dig_hi_reg};
			`LCDAN_OFS_BAR_LO: rd_data = bar_lo_reg;
			`LCDAN_OFS_BAR_HI: rd_data = {18'h0, bar_hi_reg};
			`LCDAN_OFS_STAT: rd_data = stat;
			`LCDAN_OFS_ROW1: rd_data = {1'b0, row1_reg};
			`LCDAN_OFS_ROW2: rd_data = {1'b0, row2_reg};
			`LCDAN_OFS_ROW3: rd_data = {1'b0, row3_reg};
			`LCDAN_OFS_ROW4: rd_data = {1'b0, row4_reg};
			default: begin
				rd_ok = 1'b0;
				rd_data = 32'h0000_0000;
			end
		endcase
	end
endmodule // lcdan_top

// File: bench/lcdan_glass.sv
`timescale 1ns/1ps
// ==========================================
// glass model: reads lit crossings back as symbols
// the glass only shows what the rows drive; it never answers back
module lcdan_glass (
	input wire [30:0] i_row1,
	input wire [30:0] i_row2,
	input wire [30:0] i_row3,
	input wire [30:0] i_row4,
	output wire [29:0] o_symbols
);
	assign o_symbols = {i_row1[0], i_row2[1], i_row1[1], i_row3[29],
		i_row2[29], i_row1[29], i_row1[24], i_row1[23], i_row2[23],
		i_row2[24], i_row3[30], i_row2[30], i_row3[27], i_row2[27],
		i_row1[27], i_row1[11], i_row1[7], i_row1[3], i_row2[2], i_row1[2],
		i_row1[20], i_row1[19], i_row1[18], i_row2[26], i_row1[15],
		i_row1[16], i_row4[29], i_row2[25], i_row1[26], i_row1[25]};
endmodule // lcdan_glass

// File: bench/lcdan_top_asserts.sv
`timescale 1ns/1ps
// ==========================================
// symbol and bus checks on the top ports
module lcdan_top_chk (
	input wire i_sys_clk,
	input wire i_arst_n,
	input wire i_arvalid,
	input wire o_arready,
	input wire o_rvalid,
	input wire i_rready,
	input wire [31:0] o_rdata,
	input wire o_bvalid,
	input wire i_bready,
	input wire [1:0] o_bresp,
	input wire [30:0] o_backplane_line_one,
	input wire [30:0] o_backplane_line_two,
	input wire [30:0] o_backplane_line_three,
	input wire [30:0] o_backplane_line_four
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	wire [30:0] r1 = o_backplane_line_one;
	wire [30:0] r2 = o_backplane_line_two;
	wire [30:0] r3 = o_backplane_line_three;
	wire [30:0] r4 = o_backplane_line_four;
	// corner crossing lights only in segment test, so it marks that mode
	wire tst = r1[30];
	wire [2:0] cap_pfx = {r3[29], r2[29], r1[29]};
	sequence ar_take;
		i_arvalid && o_arready;
	endsequence
	sequence r_wait;
		o_rvalid && !i_rready;
	endsequence
	unit_onehot_a: assert property (
		!tst |-> $onehot0({r1[25], r1[26], r2[25], r4[29]}))
		else $error("two unit symbols lit");
	dc_ac_excl_a: assert property (
		!tst |-> !(r1[2] && r2[2]))
		else $error("dc and ac lit together");
	auto_manual_a: assert property (
		!tst && (r1[3] || r1[7]) |-> r1[3] != r1[7])
		else $error("auto and manual lit together");
	cap_prefix_a: assert property (
		!tst |-> $onehot0(cap_pfx) && ((cap_pfx != 3'h0) == r4[29]))
		else $error("capacitance prefix wrong");
	ohm_prefix_a: assert property (
		!tst && (r2[23] || r2[24]) |-> r2[25] && !(r2[23] && r2[24]))
		else $error("ohm prefix wrong");
	amp_micro_a: assert property (
		!tst && r1[23] |-> r1[26])
		else $error("micro without amperes");
	va_milli_a: assert property (
		!tst && r1[24] |-> r1[25] || r1[26])
		else $error("milli without volts or amperes");
	temp_unit_a: assert property (
		!tst |-> !(r1[19] && r1[20]))
		else $error("both temperature units lit");
	hz_pct_a: assert property (
		!tst |-> !(r2[26] && r1[18]))
		else $error("hertz and percent lit together");
	extreme_excl_a: assert property (
		!tst |-> !(r2[27] && r3[27]))
		else $error("max and min lit together");
	test_corner_a: assert property (
		r4[30] == r1[30])
		else $error("corner crossings disagree");
	read_answer_a: assert property (ar_take |=> o_rvalid)
		else $error("read answer late");
	read_hold_a: assert property (r_wait |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped");
	write_hold_a: assert property (
		o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped");
endmodule // lcdan_top_chk

bind lcdan_top lcdan_top_chk lcdan_top_chk_i (
	.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_arvalid(i_arvalid),
	.o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready),
	.o_rdata(o_rdata), .o_bvalid(o_bvalid), .i_bready(i_bready),
	.o_bresp(o_bresp), .o_backplane_line_one(o_backplane_line_one),
	.o_backplane_line_two(o_backplane_line_two),
	.o_backplane_line_three(o_backplane_line_three),
	.o_backplane_line_four(o_backplane_line_four)
);

// File: bench/tb_lcd_annunciator_decoder.sv
`timescale 1ns/1ps
`include "lcdan_defs.vh"
module tb_lcd_annunciator_decoder;
	logic i_sys_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [7:0] i_awaddr = 8'h00;
	logic [7:0] i_araddr = 8'h00;
	logic [31:0] i_wdata = 32'h00000000;
	logic [3:0] i_wstrb = 4'hf;
	logic i_awvalid = 1'b0;
	logic i_wvalid = 1'b0;
	logic i_bready = 1'b0;
	logic i_arvalid = 1'b0;
	logic i_rready = 1'b0;
	wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	wire [1:0] o_bresp, o_rresp;
	wire [31:0] o_rdata;
	wire [30:0] row1, row2, row3, row4;
	wire [29:0] sym;
	int miscompares = 0;
	int comparisons = 0;
	logic [31:0] lfsr = 32'h00015ddb;
	logic [6:0] codes [12] = '{`LCDAN_FN_VOLT, `LCDAN_FN_UAMP,
		`LCDAN_FN_MAMP, `LCDAN_FN_A22, `LCDAN_FN_AMAN, `LCDAN_FN_OHM,
		`LCDAN_FN_CONT, `LCDAN_FN_DIODE, `LCDAN_FN_FREQ, `LCDAN_FN_CAP,
		`LCDAN_FN_TEMP, `LCDAN_FN_ADP};

	always #2.5 i_sys_clk = ~i_sys_clk;

	lcdan_top lcdan_top_i (
		.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
		.i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
		.o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
		.i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
		.o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
		.i_rready(i_rready), .o_backplane_line_one(row1),
		.o_backplane_line_two(row2), .o_backplane_line_three(row3),
		.o_backplane_line_four(row4)
	);
	lcdan_glass lcdan_glass_i (.i_row1(row1), .i_row2(row2), .i_row3(row3),
		.i_row4(row4), .o_symbols(sym));

	// ==========================================
	// helpers
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	function automatic logic [29:0] model(input logic [6:0] f,
			input logic [6:0] rg, input logic [15:0] fl);
		logic [29:0] e;
		logic cur;
		logic va;
		int ix;
		ix = int'(rg) - 48;
		cur = f == `LCDAN_FN_UAMP || f == `LCDAN_FN_MAMP ||
			f == `LCDAN_FN_A22 || f == `LCDAN_FN_AMAN;
		va = cur || f == `LCDAN_FN_VOLT;
		e = '0;
		e[0] = f == `LCDAN_FN_VOLT || f == `LCDAN_FN_DIODE;
		e[1] = cur;
		e[2] = f == `LCDAN_FN_OHM || f == `LCDAN_FN_CONT;
		e[3] = f == `LCDAN_FN_CAP;
		e[4] = f == `LCDAN_FN_CONT;
		e[5] = f == `LCDAN_FN_DIODE;
		e[6] = f == `LCDAN_FN_FREQ && fl[7];
		e[7] = f == `LCDAN_FN_FREQ && !fl[7];
		e[8] = f == `LCDAN_FN_TEMP && fl[7];
		e[9] = f == `LCDAN_FN_TEMP && !fl[7];
		e[10] = va && !fl[8];
		e[11] = va && fl[8];
		e[12] = fl[0];
		e[13] = !fl[0];
		e[14] = fl[1];
		e[15] = fl[2];
		e[16] = fl[3];
		e[17] = fl[4] && !fl[3];
		e[18] = fl[5];
		e[19] = fl[6] && !fl[5];
		e[20] = f == `LCDAN_FN_OHM && ix >= 1 && ix <= 3;
		e[21] = f == `LCDAN_FN_OHM && ix >= 4 && ix <= 6;
		e[22] = f == `LCDAN_FN_UAMP && !fl[9];
		e[23] = (f == `LCDAN_FN_VOLT && rg == `LCDAN_RG_220MV) ||
			(f == `LCDAN_FN_MAMP && !fl[9]);
		e[24] = e[3] && ix <= 1;
		e[25] = e[3] && ix >= 2 && ix <= 4;
		e[26] = e[3] && ix >= 5;
		e[27] = fl[10];
		e[28] = fl[11];
		e[29] = fl[12];
		return e;
	endfunction

	task automatic check(input string name, input logic [31:0] seen,
			input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %0s expected %h seen %h", name, exp, seen);
		end
	endtask

	// slow holds back the response ready for a few cycles
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
			input logic slow, output logic [1:0] r);
		bit aw_ok;
		bit w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge i_sys_clk);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= !slow;
		while (!(aw_ok && w_ok)) begin
			@(posedge i_sys_clk);
			if (i_awvalid && o_awready) begin
				aw_ok = 1;
				i_awvalid <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_ok = 1;
				i_wvalid <= 1'b0;
			end
		end
		if (slow) begin
			repeat (3) @(posedge i_sys_clk);
			i_bready <= 1'b1;
		end
		do @(posedge i_sys_clk); while (!(o_bvalid && i_bready));
		r = o_bresp;
		i_bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, input logic slow,
			output logic [31:0] d, output logic [1:0] r);
		@(posedge i_sys_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= !slow;
		do @(posedge i_sys_clk); while (!o_arready);
		i_arvalid <= 1'b0;
		if (slow) begin
			repeat (3) @(posedge i_sys_clk);
			i_rready <= 1'b1;
		end
		do @(posedge i_sys_clk); while (!(o_rvalid && i_rready));
		d = o_rdata;
		r = o_rresp;
		i_rready <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic slow);
		logic [1:0] r;
		axi_write(a, d, slow, r);
		check("write response", 32'(r), 32'(`LCDAN_RESP_OKAY));
	endtask

	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================
	// sequence of tests
	initial begin
		repeat (50000) @(posedge i_sys_clk);
		miscompares++;
		print_verdict();
	end

	initial begin
		logic [1:0] r;
		logic [31:0] d;
		logic [6:0] f;
		logic [6:0] rg;
		logic [15:0] fl;
		logic [4:0] ad;
		logic [29:0] e;
		repeat (8) @(posedge i_sys_clk);
		i_arst_n <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		e = model(`LCDAN_RST_FUNC, `LCDAN_RST_RANGE, `LCDAN_RST_FLAGS);
		check("reset symbols", 32'(sym), 32'(e));
		axi_read(`LCDAN_OFS_FUNC, 1'b0, d, r);
		check("function reset", d, 32'(`LCDAN_RST_FUNC));
		axi_read(`LCDAN_OFS_RANGE, 1'b0, d, r);
		check("range reset", d, 32'(`LCDAN_RST_RANGE));
		axi_read(`LCDAN_OFS_FLAGS, 1'b0, d, r);
		check("flags reset", d, 32'(`LCDAN_RST_FLAGS));
		$display("test reset done");
		// segment test and blank kept out: they override every symbol
		for (int k = 0; k < 96; k++) begin
			f = codes[k % 12];
			rg = 7'h30 + 7'(rnd() % 8);
			fl = 16'(rnd()) & 16'h3fff;
			wr(`LCDAN_OFS_FUNC, 32'(f), k[0]);
			wr(`LCDAN_OFS_RANGE, 32'(rg), 1'b0);
			wr(`LCDAN_OFS_FLAGS, 32'(fl), 1'b0);
			repeat (2) @(posedge i_sys_clk);
			e = model(f, rg, fl);
			check("unit symbols", 32'(sym[5:0]), 32'(e[5:0]));
			check("hz pct temp", 32'(sym[9:6]), 32'(e[9:6]));
			check("dc ac", 32'(sym[11:10]), 32'(e[11:10]));
			check("mode symbols", 32'(sym[19:12]), 32'(e[19:12]));
			check("prefixes", 32'(sym[26:20]), 32'(e[26:20]));
			check("feature symbols", 32'(sym), 32'(e));
			axi_read(`LCDAN_OFS_STAT, k[1], d, r);
			check("status", 32'(d[26:0]), 32'(e[26:0]));
			ad = 5'h0;
			if (f == `LCDAN_FN_ADP && rg < 7'h35)
				ad = 5'h10 >> (rg - 7'h30);
			check("adapter", 32'(d[31:27]), 32'(ad));
		end
		$display("test symbols done");
		check("bars clear", 32'(row3[26:0] | row4[26:0]), 32'h0);
		wr(`LCDAN_OFS_DIG_LO, 32'h0fffffff, 1'b0);
		wr(`LCDAN_OFS_DIG_HI, 32'h000007ff, 1'b1);
		wr(`LCDAN_OFS_BAR_LO, 32'hffffffff, 1'b0);
		wr(`LCDAN_OFS_BAR_HI, 32'h00003fff, 1'b0);
		repeat (2) @(posedge i_sys_clk);
		check("bars", 32'(row3[26:0] & row4[26:0]), 32'h07ffffff);
		check("digit row", 32'(row2[22:4]), 32'h0007ffff);
		$display("test digits done");
		wr(`LCDAN_OFS_FLAGS, (32'h1 << `LCDAN_FL_TEST) | 32'h1, 1'b0);
		repeat (2) @(posedge i_sys_clk);
		check("test row one", 32'(row1), 32'h7fffffff);
		check("test row four", 32'(row4), 32'h7fffffff);
		wr(`LCDAN_OFS_FLAGS, (32'h3 << `LCDAN_FL_TEST) | 32'h1, 1'b0);
		repeat (2) @(posedge i_sys_clk);
		check("blank rows", 32'(row1 | row2 | row3 | row4), 32'h0);
		i_wstrb <= 4'h2;
		wr(`LCDAN_OFS_FLAGS, 32'h0000ffff, 1'b0);
		i_wstrb <= 4'hf;
		axi_read(`LCDAN_OFS_FLAGS, 1'b0, d, r);
		check("byte enables", d, 32'h0000ff01);
		$display("test segment check done");
		axi_write(8'h40, 32'h0000003b, 1'b1, r);
		check("unmapped write", 32'(r), 32'(`LCDAN_RESP_SLVERR));
		axi_write(`LCDAN_OFS_STAT, 32'h00000000, 1'b0, r);
		check("read-only write", 32'(r), 32'(`LCDAN_RESP_SLVERR));
		axi_read(8'h40, 1'b1, d, r);
		check("unmapped data", d, 32'h00000000);
		check("unmapped read", 32'(r), 32'(`LCDAN_RESP_SLVERR));
		$display("test bus errors done");
		print_verdict();
	end
endmodule // tb_lcd_annunciator_decoder
